// [hw/hpc_top.sv]
// host port pin control: strap capture, address latch, ready and irq pins
// assumes pins arrive asynchronously; device_reset_n goes through the same synchronisers as the strap, output-off, strobe and direction pins
//
// What this block does
// - A multiplexed host pulses the address latch strobe and the device captures the address.
// - The direction input selects read or write and the device acts on that direction.
// - The ready output tells the host whether the next transfer can be taken.
// - Ready is high impedance while the global output-off input is low.
// - The device drives a host interrupt output to request service.
// - The host interrupt output is driven high while the device is in reset.
// - With the port disabled the interrupt pin carries the second timer output.
// - The host interrupt output is high impedance while output-off is low.
// - The enable strap is sampled at the rising edge of device reset and latched.
`timescale 1ns/1ps
module hpc_top
    import hpc_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  wire logic              clk_en_i,
    input  wire logic              device_reset_n_i,
    input  wire logic              port_enable_strap_i,
    input  wire logic              outputs_off_n_i,
    input  wire logic              addr_strobe_n_i,
    input  wire logic              data_strobe_n_i,
    input  wire logic              host_dir_select_i,
    input  wire logic [ADDR_W-1:0] host_addr_i,
    input  wire logic              irq_req_i,
    input  wire logic              timer_b_output_i,
    output logic                   port_ready_out_o,
    output logic                   port_ready_oe_o,
    output logic                   host_irq_out_o,
    output logic                   host_irq_oe_o,
    output logic                   port_enabled_o,
    output logic [ADDR_W-1:0]      addr_reg_o,
    output logic                   wr_pulse_o,
    output logic                   rd_pulse_o
);
    // ========================================================
    // pin synchronisers: three stages, change once 2nd and 3rd agree
    localparam int unsigned NSYNC = 6;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff, flt_ff;
    logic [NSYNC-1:0] nxt_s1, nxt_s2, nxt_s3, nxt_flt;
    assign pin_raw = {device_reset_n_i, port_enable_strap_i, outputs_off_n_i,
                      addr_strobe_n_i, data_strobe_n_i, host_dir_select_i};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_comb begin
                nxt_s1[gi]  = pin_raw[gi];
                nxt_s2[gi]  = s1_ff[gi];
                nxt_s3[gi]  = s2_ff[gi];
                nxt_flt[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : flt_ff[gi];
            end
        end
    endgenerate
    // device reset is seen as asserted after logic reset so irq stays high
    // until the pin is really released; other pins are seen inactive
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s1_ff  <= 6'h1f;
            s2_ff  <= 6'h1f;
            s3_ff  <= 6'h1f;
            flt_ff <= 6'h1f;
        end else if (clk_en_i) begin
            s1_ff  <= nxt_s1;
            s2_ff  <= nxt_s2;
            s3_ff  <= nxt_s3;
            flt_ff <= nxt_flt;
        end
    end
    logic dev_rst_n, strap, off_n, as_n, ds_n, dir_rd;
    assign {dev_rst_n, strap, off_n, as_n, ds_n, dir_rd} = flt_ff;
    // host address bus is sampled under the strobe; assumed stable around it
    logic [ADDR_W-1:0] addr_pipe_ff;

    // ========================================================
    // strap capture and transfer control
    hpc_state_t        state_ff, nxt_state;
    logic              rstn_d_ff, nxt_rstn_d;
    logic              en_ff, nxt_en;
    logic              as_d_ff, nxt_as_d;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [1:0]        cnt_ff, nxt_cnt;
    logic              wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic              rdy_ff, nxt_rdy, rdy_oe_ff, nxt_rdy_oe;
    logic              irq_ff, nxt_irq, irq_oe_ff, nxt_irq_oe;

    always_comb begin
        nxt_rstn_d = dev_rst_n;
        nxt_en     = en_ff;
        nxt_as_d   = as_n;
        nxt_addr   = addr_ff;
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_wr     = 1'b0;
        nxt_rd     = 1'b0;
        if (dev_rst_n && !rstn_d_ff) begin
            nxt_en = strap;
        end
        if (!dev_rst_n) begin
            nxt_state = HPC_IDLE;
        end else if (en_ff) begin
            // falling edge of the latch strobe captures the address phase
            if (as_d_ff && !as_n) begin
                nxt_addr = addr_pipe_ff;
            end
            case (state_ff)
                HPC_IDLE: begin
                    if (!ds_n) begin
                        nxt_state = dir_rd ? HPC_READ : HPC_WRITE;
                    end
                end
                HPC_WRITE: begin
                    nxt_wr    = 1'b1;
                    nxt_cnt   = BUSY_CYC_W;
                    nxt_state = HPC_BUSY;
                end
                HPC_READ: begin
                    nxt_rd    = 1'b1;
                    nxt_cnt   = BUSY_CYC_W;
                    nxt_state = HPC_BUSY;
                end
                HPC_BUSY: begin
                    // wait for strobe release so one strobe is one transfer
                    if (cnt_ff != 2'h0) begin
                        nxt_cnt = cnt_ff - 2'h1;
                    end else if (ds_n) begin
                        nxt_state = HPC_IDLE;
                    end
                end
                default: nxt_state = HPC_IDLE;
            endcase
        end else begin
            nxt_state = HPC_IDLE;
        end
        nxt_rdy    = en_ff && dev_rst_n && (state_ff == HPC_IDLE) && (nxt_state == HPC_IDLE);
        nxt_rdy_oe = off_n;
        if (!dev_rst_n) begin
            nxt_irq = 1'b1;
        end else if (en_ff) begin
            nxt_irq = !irq_req_i;
        end else begin
            nxt_irq = timer_b_output_i;
        end
        nxt_irq_oe = off_n;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rstn_d_ff    <= 1'b0;
            en_ff        <= STRAP_RST;
            as_d_ff      <= 1'b1;
            addr_ff      <= ADDR_RST;
            addr_pipe_ff <= ADDR_RST;
            state_ff     <= HPC_IDLE;
            cnt_ff       <= 2'h0;
            wr_ff        <= 1'b0;
            rd_ff        <= 1'b0;
            rdy_ff       <= 1'b0;
            rdy_oe_ff    <= 1'b0;
            irq_ff       <= 1'b1;
            irq_oe_ff    <= 1'b0;
        end else if (clk_en_i) begin
            rstn_d_ff    <= nxt_rstn_d;
            en_ff        <= nxt_en;
            as_d_ff      <= nxt_as_d;
            addr_ff      <= nxt_addr;
            addr_pipe_ff <= host_addr_i;
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            wr_ff        <= nxt_wr;
            rd_ff        <= nxt_rd;
            rdy_ff       <= nxt_rdy;
            rdy_oe_ff    <= nxt_rdy_oe;
            irq_ff       <= nxt_irq;
            irq_oe_ff    <= nxt_irq_oe;
        end
    end

    assign port_ready_out_o = rdy_ff;
    assign port_ready_oe_o  = rdy_oe_ff;
    assign host_irq_out_o   = irq_ff;
    assign host_irq_oe_o    = irq_oe_ff;
    assign port_enabled_o   = en_ff;
    assign addr_reg_o       = addr_ff;
    assign wr_pulse_o       = wr_ff;
    assign rd_pulse_o       = rd_ff;

    // ========================================================
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_strap_capture: assert property (
        clk_en_i && dev_rst_n && !rstn_d_ff |=> en_ff == $past(strap))
        else $error("strap not latched at reset release");
    a_strap_hold: assert property (
        !(dev_rst_n && !rstn_d_ff) && clk_en_i |=> $stable(en_ff))
        else $error("port enable changed outside reset release");
    a_addr_latch: assert property (
        clk_en_i && en_ff && dev_rst_n && as_d_ff && !as_n |=> addr_ff == $past(addr_pipe_ff))
        else $error("address not captured on latch strobe");
    a_dir_write: assert property (
        clk_en_i && en_ff && dev_rst_n && state_ff == HPC_IDLE && !ds_n && !dir_rd
        ##1 (clk_en_i && dev_rst_n) ##1 clk_en_i |-> wr_ff && !rd_ff)
        else $error("write direction not honoured");
    a_dir_read: assert property (
        clk_en_i && en_ff && dev_rst_n && state_ff == HPC_IDLE && !ds_n && dir_rd
        ##1 (clk_en_i && dev_rst_n) ##1 clk_en_i |-> rd_ff && !wr_ff)
        else $error("read direction not honoured");
    a_ready_busy: assert property (
        clk_en_i && state_ff == HPC_BUSY |=> !port_ready_out_o)
        else $error("ready high while busy");
    a_ready_off: assert property (
        clk_en_i && !off_n |=> !port_ready_oe_o && !host_irq_oe_o)
        else $error("outputs driven while output-off low");
    a_irq_reset: assert property (
        clk_en_i && !dev_rst_n |=> host_irq_out_o)
        else $error("irq not high during device reset");
    a_irq_timer: assert property (
        clk_en_i && dev_rst_n && !en_ff |=> host_irq_out_o == $past(timer_b_output_i))
        else $error("timer output not routed when disabled");
    a_irq_req: assert property (
        clk_en_i && dev_rst_n && en_ff && irq_req_i |=> !host_irq_out_o)
        else $error("irq request not signalled");
    a_disabled_idle: assert property (
        !en_ff |-> !wr_pulse_o && !rd_pulse_o)
        else $error("transfer while port disabled");

    c_write: cover property (wr_pulse_o);
    c_read: cover property (rd_pulse_o);
    c_enable: cover property (dev_rst_n && !rstn_d_ff && strap);
    c_timer: cover property (!en_ff && dev_rst_n && timer_b_output_i);
endmodule

// [shared/hpc_pkg.sv]
// package for the host port pin control block
// assumes a single 40 MHz system clock domain
package hpc_pkg;
    // address register width of the 8-bit port
    localparam int unsigned ADDR_W          = 8;
    localparam logic [7:0]  ADDR_RST        = 8'h00;
    // ready recovery after a transfer strobe, in cycles
    localparam int unsigned BUSY_CYC        = 2;
    localparam logic [1:0]  BUSY_CYC_W      = 2'h2;
    localparam logic        STRAP_RST       = 1'b0;

    typedef enum logic [1:0] {
        HPC_IDLE  = 2'b00,
        HPC_WRITE = 2'b01,
        HPC_READ  = 2'b10,
        HPC_BUSY  = 2'b11
    } hpc_state_t;
endpackage

// [sim/hpc_host_model.sv]
// host side model: address latch strobe, data strobe and direction
// assumes the bench calls its tasks just after a rising clock edge
`timescale 1ns/1ps
module hpc_host_model
    import hpc_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              port_ready_out_i,
    output logic                   addr_strobe_n_o,
    output logic                   data_strobe_n_o,
    output logic                   host_dir_select_o,
    output logic [ADDR_W-1:0]      host_addr_o
);
    // ==========================================================
    // host cycles
    initial begin
        addr_strobe_n_o = 1'b1;
        data_strobe_n_o = 1'b1;
        host_dir_select_o = 1'b1;
        host_addr_o = 8'h00;
    end

    // address held well past the strobe fall, which the pin filter delays
    task automatic latch_addr(input logic [ADDR_W-1:0] a);
        @(posedge sys_clk_i) #1 host_addr_o = a;
        @(posedge sys_clk_i) #1 addr_strobe_n_o = 1'b0;
        repeat (6) @(posedge sys_clk_i);
        #1 addr_strobe_n_o = 1'b1;
        repeat (2) @(posedge sys_clk_i);
        // released bus shows the inverted value, not the last one
        #1 host_addr_o = ~a;
    endtask

    // ready is looked at off the edge; late reports a wait that ran out
    task automatic xfer(input logic rd, output logic late);
        int k;
        @(posedge sys_clk_i) #1;
        for (k = 0; k < 20 && port_ready_out_i !== 1'b1; k++) begin
            @(posedge sys_clk_i) #1;
        end
        late = (port_ready_out_i !== 1'b1);
        host_dir_select_o = rd;
        data_strobe_n_o = 1'b0;
        repeat (8) @(posedge sys_clk_i);
        #1 data_strobe_n_o = 1'b1;
        @(posedge sys_clk_i) #1 host_dir_select_o = ~rd;
    endtask
endmodule

// [sim/testbench.sv]
// self-checking bench for the host port pin control block
// assumes one 40 MHz clock and the host model on the strobe pins
`timescale 1ns/1ps
module testbench;
    import hpc_pkg::*;
    logic              sys_clk_i, rst_i, dev_rst_n, strap, off_n, irq_req, tmr;
    logic              as_n, ds_n, dir, rdy, rdy_oe, irq, irq_oe, en, wr, rd;
    logic [ADDR_W-1:0] haddr, areg, keep;
    int                n_mismatch, n_compared, n_wr, n_rd, n_low;

    hpc_top u_hpc_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(1'b1),
        .device_reset_n_i(dev_rst_n), .port_enable_strap_i(strap), .outputs_off_n_i(off_n),
        .addr_strobe_n_i(as_n), .data_strobe_n_i(ds_n), .host_dir_select_i(dir),
        .host_addr_i(haddr), .irq_req_i(irq_req), .timer_b_output_i(tmr),
        .port_ready_out_o(rdy), .port_ready_oe_o(rdy_oe), .host_irq_out_o(irq),
        .host_irq_oe_o(irq_oe), .port_enabled_o(en), .addr_reg_o(areg),
        .wr_pulse_o(wr), .rd_pulse_o(rd));
    hpc_host_model u_hpc_host_model (.sys_clk_i(sys_clk_i), .port_ready_out_i(rdy),
        .addr_strobe_n_o(as_n), .data_strobe_n_o(ds_n), .host_dir_select_o(dir),
        .host_addr_o(haddr));

    // ==========================================================
    // helpers
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // pulses last one cycle, so every cycle of the window is looked at
    task automatic watch(input int n);
        n_wr = 0; n_rd = 0; n_low = 0;
        repeat (n) begin
            cyc(1);
            n_wr += (wr === 1'b1);
            n_rd += (rd === 1'b1);
            n_low += (rdy === 1'b0);
        end
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic boot(input logic s);
        dev_rst_n = 1'b0;
        strap = s;
        cyc(8);
        check(irq, 1'b1);
        dev_rst_n = 1'b1;
        cyc(8);
        strap = ~s;
        cyc(2);
        check(en, s);
    endtask
    // ok low: port disabled, so the host wait runs out and nothing moves
    task automatic t_xfer(input logic r, input logic ok);
        logic late;
        fork
            u_hpc_host_model.xfer(r, late);
            watch(36);
        join
        check(late, !ok);
        check(n_wr, ok && !r);
        check(n_rd, ok && r);
        check(n_low > 0, 1'b1);
        check(rdy, ok);
    endtask
    task automatic t_irq_off;
        irq_req = 1'b1;
        cyc(3);
        check({irq, irq_oe}, 2'h1);
        off_n = 1'b0;
        cyc(8);
        check(rdy_oe, 1'b0);
        check(irq_oe, 1'b0);
        off_n = 1'b1;
        irq_req = 1'b0;
        cyc(8);
    endtask
    task automatic t_disabled;
        boot(1'b0);
        tmr = 1'b1;
        cyc(3);
        check(irq, 1'b1);
        tmr = 1'b0;
        cyc(3);
        check(irq, 1'b0);
        keep = areg;
        u_hpc_host_model.latch_addr(8'h3C);
        t_xfer(1'b0, 1'b0);
        check(n_wr + n_rd, 8'h00);
        check(areg, keep);
    endtask

    initial begin
        n_mismatch = 0; n_compared = 0;
        rst_i = 1'b1; dev_rst_n = 1'b0; strap = 1'b1;
        off_n = 1'b1; irq_req = 1'b0; tmr = 1'b0;
        cyc(6);
        rst_i = 1'b0;
        boot(1'b1);
        u_hpc_host_model.latch_addr(8'hA5);
        cyc(6);
        check(areg, 8'hA5);
        t_xfer(1'b0, 1'b1);
        t_xfer(1'b1, 1'b1);
        t_irq_off();
        t_disabled();
        stop_test();
    end
endmodule
